/* core/pmc_ctrl.sv */
// Power mode controller: chooses asleep, awake or periodic wakeup and gates power.
// Assumes qualifier inputs are synchronous single-bit levels or one-cycle pulses.
//
// Functional notes
// RQ1: Exactly one of three power modes held.
// RQ2: Asleep removes internal power, switched output, CPU.
// RQ3: Input pin changes recorded while asleep.
// RQ4: Awake powers everything and switched output.
// RQ5: Periodic powers internals, switched output off.
// RQ6: Power-up awake conditions in priority order.
// RQ7: Boot wake flag gives periodic, then asleep.
// RQ8: Otherwise asleep at once, power-up report queued.
// RQ9: Awake held while any stay condition holds; the code ignores them during drain and still goes asleep once the send is done.
// RQ10: Sleep request runs timer up to delay.
// RQ11: Sleep request inactive clears timer, stays awake.
// RQ12: Sleep event queued, wait bounded by limit.
// RQ13: Asleep wakes on toggle, keep-awake, motion, request.
// RQ14: Interval expiry while asleep gives periodic wakeup.
// RQ15: Periodic sends position, bounded, then asleep.
// RQ16: Digital outputs settable and kept while asleep.
// RQ17: Serial ports follow awake and sleep.
// RQ18: Qualifiers are synchronous, valid one clock minimum.
// RQ19: Interval timer restarts on sleep, zero disables.
`timescale 1ns/10ps
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES,
  parameter int TW       = TIMER_W,
  parameter int PW       = PINS_W,
  parameter int OW       = DOUT_W
) (
  input  wire logic              clk,                 // 50 MHz system clock
  input  wire logic              reset,               // Async reset, active high
  input  wire logic [ADDR_W-1:0] addr,                // Register byte address
  input  wire logic [DATA_W-1:0] wdata,               // Write data
  input  wire logic              wr,                  // Write strobe
  input  wire logic              rd,                  // Read strobe
  output logic      [DATA_W-1:0] rdata,               // Read data, cycle after rd
  input  wire logic              alarm_active,        // Input alarm level
  input  wire logic              alarm_toggle,        // Alarm input toggled pulse
  input  wire logic              keep_awake_active,   // Keep-awake input level
  input  wire logic              motion_detected,     // Motion level
  input  wire logic              sleep_request,       // Sleep-request input level
  input  wire logic              message_sent,        // Queued message sent pulse
  input  wire logic [PW-1:0]     input_pins,          // Digital input pins
  output pmc_mode_type           mode,                // Current power mode
  output pmc_power_type          power,               // Power gates
  output logic      [OW-1:0]     digital_out,         // Remote-set outputs
  output logic                   record_valid,        // Pin change record pulse
  output logic      [PW-1:0]     record_data,         // Pin levels recorded
  output logic                   sleep_event_req,     // Queue sleep event pulse
  output logic                   power_up_report_req, // Queue power-up report pulse
  output logic                   position_req,        // Fetch and send position pulse
  output logic                   irq                  // Level interrupt
);

  function automatic pmc_power_type mode_power(input pmc_mode_type m);
    pmc_power_type p;
    p = POWER_AWAKE;
    case (m)
      PM_AWAKE: begin
        p = POWER_AWAKE;
      end
      PM_PERIODIC: begin
        p.switched_power_output = 1'b0;
      end
      default: begin
        p = '0;
        p.cpu_low_power = 1'b1;
      end
    endcase
    return p;
  endfunction

  logic [1:0]         ctrl;
  logic [TW-1:0]      sleep_delay;
  logic [TW-1:0]      interval;
  logic [TW-1:0]      send_wait;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_mask;
  logic               boot_pending;
  logic               drain;
  logic [PW-1:0]      pins_q;
  logic               tick;
  logic               sleep_expired;
  logic               interval_expired;
  logic               send_expired;
  pmc_mode_type       next_mode;
  logic               next_drain;
  logic               next_sleep_req;
  logic               next_report_req;
  logic               next_position_req;
  logic [IRQ_W-1:0]   events;
  logic [IRQ_W-1:0]   next_irq_status;

  wire start_go     = wr && addr == CTRL_OFS && wdata[CTRL_START_BIT];
  wire motion_wake  = ctrl[CTRL_MOTION_WAKE_BIT] && motion_detected;
  wire stay_awake   = alarm_active || sleep_delay == '0 || keep_awake_active || motion_wake;  // RQ9
  wire wake_asleep  = alarm_toggle || keep_awake_active || motion_wake || !sleep_request;
  wire awake_idle   = mode == PM_AWAKE && !boot_pending && !drain;
  wire sleep_run    = awake_idle && !stay_awake && sleep_request;
  wire send_waiting = drain || mode == PM_PERIODIC;
  wire send_done    = message_sent || send_expired;
  wire pin_change   = pins_q != input_pins;

  pmc_tick #(
    .CYCLES (TICK_CNT)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  pmc_timer #(
    .W (TW)
  ) u_sleep_timer (
    .clk     (clk),
    .reset   (reset),
    .clear   (!sleep_run),  // RQ11
    .tick    (tick),
    .limit   (sleep_delay),
    .expired (sleep_expired)
  );

  pmc_timer #(
    .W (TW)
  ) u_interval_timer (
    .clk     (clk),
    .reset   (reset),
    .clear   (mode != PM_ASLEEP),  // RQ19
    .tick    (tick),
    .limit   (interval),
    .expired (interval_expired)
  );

  // Bounds both the sleep-event wait and the periodic position attempt
  pmc_timer #(
    .W (TW)
  ) u_send_timer (
    .clk     (clk),
    .reset   (reset),
    .clear   (!send_waiting),  // RQ12 RQ15
    .tick    (tick),
    .limit   (send_wait),
    .expired (send_expired)
  );

  always_comb begin
    next_mode         = mode;
    next_drain        = drain;
    next_sleep_req    = 1'b0;
    next_report_req   = 1'b0;
    next_position_req = 1'b0;
    case (mode)
      PM_AWAKE: begin
        if (boot_pending) begin
          // Decision waits for software to load settings and start
          if (!start_go) begin
            next_mode = PM_AWAKE;
          end else if (alarm_active) begin
            next_mode = PM_AWAKE;  // RQ6
          end else if (sleep_delay == '0) begin
            next_mode = PM_AWAKE;
          end else if (keep_awake_active) begin
            next_mode = PM_AWAKE;
          end else if (motion_wake) begin
            next_mode = PM_AWAKE;
          end else if (!sleep_request) begin
            next_mode = PM_AWAKE;
          end else if (ctrl[CTRL_BOOT_WAKE_BIT]) begin
            next_mode         = PM_PERIODIC;  // RQ7
            next_position_req = 1'b1;
          end else begin
            next_mode       = PM_ASLEEP;  // RQ8
            next_report_req = 1'b1;
          end
        end else if (drain) begin
          if (send_done) begin
            next_mode  = PM_ASLEEP;  // RQ12
            next_drain = 1'b0;
          end
        end else if (!stay_awake && sleep_expired) begin
          next_drain     = 1'b1;  // RQ10
          next_sleep_req = 1'b1;
        end
      end
      PM_PERIODIC: begin
        if (send_done) begin
          next_mode = PM_ASLEEP;  // RQ15
        end
      end
      PM_ASLEEP: begin
        if (wake_asleep) begin
          next_mode = PM_AWAKE;  // RQ13
        end else if (interval_expired) begin
          next_mode         = PM_PERIODIC;  // RQ14
          next_position_req = 1'b1;
        end
      end
      default: begin
        next_mode = PM_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode         <= PM_AWAKE;
      drain        <= 1'b0;
      boot_pending <= 1'b1;
    end else begin
      mode  <= next_mode;  // RQ1
      drain <= next_drain;
      if (start_go) begin
        boot_pending <= 1'b0;
      end
    end
  end

  // Registered from the next mode so gates change with the mode itself
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power <= POWER_AWAKE;
    end else begin
      power <= mode_power(next_mode);  // RQ2 RQ4 RQ5 RQ17
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_event_req     <= 1'b0;
      power_up_report_req <= 1'b0;
      position_req        <= 1'b0;
    end else begin
      sleep_event_req     <= next_sleep_req;
      power_up_report_req <= next_report_req;
      position_req        <= next_position_req;
    end
  end

  // Sampling runs in every mode, so changes made while asleep are kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins_q       <= '0;
      record_valid <= 1'b0;
      record_data  <= '0;
    end else begin
      pins_q       <= input_pins;
      record_valid <= pin_change;  // RQ3
      record_data  <= input_pins;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl        <= CTRL_RESET;
      sleep_delay <= SLEEP_DLY_RESET;
      interval    <= INTERVAL_RESET;
      send_wait   <= SEND_WAIT_RESET;
      digital_out <= DOUT_RESET;
      irq_mask    <= IRQ_MASK_RESET;
    end else if (wr) begin
      case (addr)
        CTRL_OFS: begin
          ctrl <= wdata[1:0];
        end
        SLEEP_DLY_OFS: begin
          sleep_delay <= wdata[TW-1:0];
        end
        INTERVAL_OFS: begin
          interval <= wdata[TW-1:0];
        end
        SEND_WAIT_OFS: begin
          send_wait <= wdata[TW-1:0];
        end
        DOUT_OFS: begin
          digital_out <= wdata[OW-1:0];  // RQ16
        end
        IRQ_MASK_OFS: begin
          irq_mask <= wdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    events = '0;
    events[IRQ_WAKE_BIT]     = mode != PM_AWAKE && next_mode == PM_AWAKE;
    events[IRQ_SLEEP_BIT]    = mode != PM_ASLEEP && next_mode == PM_ASLEEP;
    events[IRQ_PERIODIC_BIT] = mode != PM_PERIODIC && next_mode == PM_PERIODIC;
    events[IRQ_INPUT_BIT]    = pin_change;
    next_irq_status = irq_status;
    if (wr && addr == IRQ_STAT_OFS) begin
      next_irq_status = irq_status & ~wdata[IRQ_W-1:0];
    end
    // An event in the clearing cycle wins over the clear
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        CTRL_OFS:      rdata <= DATA_W'(ctrl);
        SLEEP_DLY_OFS: rdata <= DATA_W'(sleep_delay);
        INTERVAL_OFS:  rdata <= DATA_W'(interval);
        SEND_WAIT_OFS: rdata <= DATA_W'(send_wait);
        STATE_OFS:     rdata <= DATA_W'({boot_pending, drain, mode});
        DOUT_OFS:      rdata <= DATA_W'(digital_out);
        IRQ_STAT_OFS:  rdata <= DATA_W'(irq_status);
        IRQ_MASK_OFS:  rdata <= DATA_W'(irq_mask);
        default:       rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_mode_legal: assert property (mode inside {PM_ASLEEP, PM_AWAKE, PM_PERIODIC})  // RQ1
    else $error("power mode left the three legal values");

  a_asleep_power: assert property (mode == PM_ASLEEP |->  // RQ2
    !power.gps && !power.modem && !power.switched_power_output && power.cpu_low_power)
    else $error("asleep with power still applied");

  a_awake_power: assert property (mode == PM_AWAKE |->  // RQ4
    power.gps && power.serial_port_one && power.switched_power_output && !power.cpu_low_power)
    else $error("awake without full power");

  a_periodic_power: assert property (mode == PM_PERIODIC |->  // RQ5
    power.gps && power.modem && !power.switched_power_output)
    else $error("periodic wakeup power wrong");

  a_pin_record: assert property (pins_q != input_pins |=>  // RQ3
    record_valid && record_data == $past(input_pins))
    else $error("pin change not recorded");

  a_boot_alarm: assert property (boot_pending && start_go && alarm_active |=>  // RQ6
    mode == PM_AWAKE && !boot_pending)
    else $error("boot with alarm did not stay awake");

  a_boot_sleep: assert property (boot_pending && start_go && !stay_awake && sleep_request  // RQ8
    && !ctrl[CTRL_BOOT_WAKE_BIT] |=> mode == PM_ASLEEP && power_up_report_req)
    else $error("boot did not sleep with report");

  a_stay_awake: assert property (awake_idle && stay_awake |=> mode == PM_AWAKE && !drain)  // RQ9
    else $error("left awake while a stay condition held");

  a_sleep_start: assert property (awake_idle && !stay_awake && sleep_expired |=>  // RQ10
    drain && sleep_event_req)
    else $error("sleep delay reached without sleep event");

  a_timer_clear: assert property (awake_idle && !sleep_request |=> !sleep_expired)  // RQ11
    else $error("sleep timer not cleared");

  a_drain_end: assert property (drain && send_expired |=> mode == PM_ASLEEP ##1 !drain)  // RQ12
    else $error("send wait limit did not end the wait");

  a_wake_asleep: assert property (mode == PM_ASLEEP && wake_asleep |=> mode == PM_AWAKE)  // RQ13
    else $error("wake condition ignored while asleep");

  a_interval_wake: assert property (mode == PM_ASLEEP && !wake_asleep && interval_expired  // RQ14
    |=> mode == PM_PERIODIC && position_req)
    else $error("interval expiry did not start periodic wakeup");

  a_periodic_end: assert property (mode == PM_PERIODIC && message_sent |=> mode == PM_ASLEEP)  // RQ15
    else $error("periodic wakeup did not return to sleep");

  a_dout_hold: assert property (!(wr && addr == DOUT_OFS) |=> $stable(digital_out))  // RQ16
    else $error("digital outputs changed without a write");

  a_interval_off: assert property (interval == '0 |=> !interval_expired)  // RQ19
    else $error("interval timer fired while disabled");

endmodule

/* core/pmc_pkg.sv */
// Shared constants, types and register map of the power mode controller.
// Assumes a single 50 MHz system clock domain.
package pmc_pkg;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int TIMER_W = 24;
  localparam int PINS_W  = 8;
  localparam int DOUT_W  = 8;
  localparam int IRQ_W   = 4;

  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] SLEEP_DLY_OFS = 8'h04;
  localparam logic [7:0] INTERVAL_OFS = 8'h08;
  localparam logic [7:0] SEND_WAIT_OFS = 8'h0c;
  localparam logic [7:0] STATE_OFS    = 8'h10;
  localparam logic [7:0] DOUT_OFS     = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;

  localparam int CTRL_BOOT_WAKE_BIT   = 0;
  localparam int CTRL_MOTION_WAKE_BIT = 1;
  localparam int CTRL_START_BIT       = 2;

  localparam int IRQ_WAKE_BIT     = 0;
  localparam int IRQ_SLEEP_BIT    = 1;
  localparam int IRQ_PERIODIC_BIT = 2;
  localparam int IRQ_INPUT_BIT    = 3;

  localparam logic [1:0]         CTRL_RESET      = 2'h0;
  localparam logic [TIMER_W-1:0] SLEEP_DLY_RESET = 24'h0;
  localparam logic [TIMER_W-1:0] INTERVAL_RESET  = 24'h0;
  localparam logic [TIMER_W-1:0] SEND_WAIT_RESET = 24'h0;
  localparam logic [DOUT_W-1:0]  DOUT_RESET      = 8'h0;
  localparam logic [IRQ_W-1:0]   IRQ_MASK_RESET  = 4'h0;

  typedef enum logic [1:0] {PM_ASLEEP, PM_AWAKE, PM_PERIODIC} pmc_mode_type;

  typedef struct packed {
    logic gps;
    logic modem;
    logic serial_port_one;
    logic serial_port_two;
    logic serial_port_three;
    logic switched_power_output;
    logic cpu_low_power;
  } pmc_power_type;

  localparam pmc_power_type POWER_AWAKE = 7'b1111110;

endpackage

/* core/pmc_tick.sv */
// Prescaler producing the one-cycle timebase tick for all timers.
// Assumes a free-running clock; tick is registered.
`timescale 1ns/10ps
module pmc_tick #(
  parameter int CYCLES = 50000
) (
  input  wire logic clk,    // System clock
  input  wire logic reset,  // Async reset, active high
  output logic      tick    // One pulse every CYCLES clocks
);
  logic [31:0] count;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count >= 32'(CYCLES - 1)) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule

/* core/pmc_timer.sv */
// Tick-driven up counter that flags when it reaches a software limit.
// A zero limit disables the timer; clear restarts it from zero.
`timescale 1ns/10ps
module pmc_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,      // System clock
  input  wire logic         reset,    // Async reset, active high
  input  wire logic         clear,    // Hold count at zero
  input  wire logic         tick,     // Timebase pulse
  input  wire logic [W-1:0] limit,    // Expiry count in ticks
  output logic              expired   // Level, count reached limit
);
  logic [W-1:0] count;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick && count < limit) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      expired <= 1'b0;
    end else begin
      expired <= !clear && limit != '0 && count >= limit;
    end
  end
endmodule

/* tb/pmc_far_side.sv */
// Far-side model: radio modems that send queued messages.
// Assumes request pulses on the system clock; mute means no coverage.
`timescale 1ns/10ps
module pmc_far_side (
  input  wire logic       clk,         // System clock
  input  wire logic       reset,       // Async reset, active high
  input  wire logic       send_req,    // Message queued
  input  wire logic       mute,        // No network coverage
  input  wire logic [7:0] lag,         // Cycles until sent
  output logic            message_sent // One-cycle sent pulse
);
  logic [7:0] cnt;
  logic       busy;
  // A muted link drops the message, so only a wait limit ends the drain
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy         <= 1'b0;
      cnt          <= 8'h0;
      message_sent <= 1'b0;
    end else begin
      message_sent <= 1'b0;
      if (send_req) begin
        busy <= !mute;
        cnt  <= lag;
      end else if (busy && cnt == 8'h0) begin
        busy         <= 1'b0;
        message_sent <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 8'h1;
      end
    end
  end
endmodule

/* tb/tb_pmc_ctrl.sv */
// Self-checking bench of the power mode controller.
// Assumes pmc_pkg register map and a tick of four clocks.
`timescale 1ns/10ps
module tb_pmc_ctrl
  import pmc_pkg::*;
();
  logic          clk, reset, wr, rd, al_a, al_t, keep, mot, sreq, mute;
  logic [7:0]    addr, pins, lag, dout, rec_d, last_rec, pv;
  logic [31:0]   wdata, rdata, rv;
  pmc_mode_type  mode;
  pmc_power_type power;
  logic          rec_v, sev, pur, pos, irq, msent;
  logic [7:0]    ofs[6] = '{SLEEP_DLY_OFS, INTERVAL_OFS, SEND_WAIT_OFS, DOUT_OFS, IRQ_MASK_OFS, 8'h20};
  int error_cnt = 0, tests_run = 0, cyc = 0, seed = 32'h6226;
  int n_sev = 0, n_pos = 0, n_pur = 0, n_rec = 0, i, k, n0, n1;

  pmc_ctrl #(.TICK_CNT(4)) DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .alarm_active(al_a), .alarm_toggle(al_t), .keep_awake_active(keep),
    .motion_detected(mot), .sleep_request(sreq), .message_sent(msent), .input_pins(pins),
    .mode(mode), .power(power), .digital_out(dout), .record_valid(rec_v), .record_data(rec_d),
    .sleep_event_req(sev), .power_up_report_req(pur), .position_req(pos), .irq(irq));
  pmc_far_side FAR (.clk(clk), .reset(reset), .send_req(sev | pos), .mute(mute), .lag(lag),
    .message_sent(msent));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc   <= cyc + 1;
    n_sev <= n_sev + int'(sev === 1'b1);
    n_pos <= n_pos + int'(pos === 1'b1);
    n_pur <= n_pur + int'(pur === 1'b1);
    n_rec <= n_rec + int'(rec_v === 1'b1);
    if (rec_v === 1'b1) begin
      last_rec <= rec_d;
    end
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic pmc_power_type exp_pwr(input pmc_mode_type m);
    case (m)
      PM_AWAKE:    return 7'h7e;
      PM_PERIODIC: return 7'h7c;
      default:     return 7'h01;
    endcase
  endfunction

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_mode(input pmc_mode_type m, input int lim);
    k = 0;
    while (mode !== m && k < lim) begin
      @(posedge clk);
      #1 k++;
    end
    chk(32'(mode), 32'(m));
    chk(32'(power), 32'(exp_pwr(m)));
  endtask

  // Drops every stay condition and asks for sleep; the delay is three ticks
  task automatic go_sleep(input int lim);
    n0 = n_sev;
    @(posedge clk);
    al_a <= 1'b0;
    keep <= 1'b0;
    mot  <= 1'b0;
    sreq <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(32'(mode), 32'(PM_AWAKE));
    wait_mode(PM_ASLEEP, lim);
    chk(32'(n_sev - n0), 32'h1);
  endtask

  task automatic endt(input string s);
    $display("test %s done at %0t ns", s, $time);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
  endtask

  initial begin
    {reset, wr, rd, al_a, al_t, keep, mot, sreq, mute} = 9'h102;
    addr  = 8'h0;
    wdata = 32'h0;
    pins  = 8'h0;
    lag   = 8'h14;
    do_reset();
    rreg(STATE_OFS, rv);
    chk(rv, 32'h9);
    foreach (ofs[j]) begin
      rreg(ofs[j], rv);
      chk(rv, 32'h0);
    end
    endt("reset values");
    // Boot flag stays set in the awake cases to prove their priority over it
    for (i = 0; i < 7; i++) begin
      do_reset();
      wreg(SLEEP_DLY_OFS, (i == 1) ? 32'h0 : 32'h3);
      @(posedge clk);
      al_a <= (i == 0);
      keep <= (i == 2);
      mot  <= (i == 3);
      sreq <= (i != 4);
      n0 = n_pos;
      n1 = n_pur;
      // The decision reads the stored flags, so they land one write ahead of start
      wreg(CTRL_OFS, (i < 6) ? 32'h3 : 32'h2);
      wreg(CTRL_OFS, (i < 6) ? 32'h7 : 32'h6);
      repeat (3) @(posedge clk);
      wait_mode((i < 5) ? PM_AWAKE : (i == 5) ? PM_PERIODIC : PM_ASLEEP, 4);
      chk(32'(n_pos - n0), 32'(i == 5));
      chk(32'(n_pur - n1), 32'(i == 6));
      if (i == 5) begin
        wait_mode(PM_ASLEEP, 40);
      end
    end
    endt("power-up choice");
    lag = 8'h3;
    rv  = $random(seed);
    wreg(DOUT_OFS, {24'h0, rv[7:0]});
    rreg(DOUT_OFS, wdata);
    chk(wdata, {24'h0, rv[7:0]});
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      al_t <= (i == 0);
      al_a <= (i == 0);
      keep <= (i == 1);
      mot  <= (i == 2);
      sreq <= (i != 3);
      @(posedge clk);
      al_t <= 1'b0;
      wait_mode(PM_AWAKE, 4);
      repeat (40) @(posedge clk);
      #1 chk(32'(mode), 32'(PM_AWAKE));
      go_sleep(80);
    end
    endt("wake and sleep");
    @(posedge clk);
    sreq <= 1'b0;
    mute <= 1'b1;
    wait_mode(PM_AWAKE, 4);
    wreg(SEND_WAIT_OFS, 32'h2);
    go_sleep(80);
    chk(32'(dout), {24'h0, rv[7:0]});
    n0 = n_pos;
    wreg(INTERVAL_OFS, 32'h2);
    wait_mode(PM_PERIODIC, 40);
    @(posedge clk);
    #1 chk(32'(n_pos - n0), 32'h1);
    wait_mode(PM_ASLEEP, 40);
    wreg(INTERVAL_OFS, 32'h0);
    repeat (60) @(posedge clk);
    #1 chk(32'(mode), 32'(PM_ASLEEP));
    endt("send wait and interval");
    for (i = 0; i < 4; i++) begin
      rv = $random(seed);
      pv = pins ^ (rv[7:0] | 8'h01);
      n0 = n_rec;
      @(posedge clk);
      pins <= pv;
      repeat (3) @(posedge clk);
      #1 chk(32'(n_rec - n0), 32'h1);
      chk(32'(last_rec), 32'(pv));
    end
    chk(32'(mode), 32'(PM_ASLEEP));
    endt("pin records");
    rreg(IRQ_STAT_OFS, rv);
    chk(rv, 32'hf);
    #1 chk(32'(irq), 32'h0);
    wreg(IRQ_MASK_OFS, 32'h8);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h1);
    wreg(IRQ_STAT_OFS, 32'h8);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0);
    rreg(IRQ_STAT_OFS, rv);
    chk(rv, 32'h7);
    endt("interrupts");
    tally_and_finish();
  end
endmodule
